// [hdl/pgh_gpio_pkg.sv]
/*
 * pgh_gpio_pkg: constants for the port g / port h general purpose i/o block.
 * holds register offsets on the wishbone slave, field positions, reset values,
 * widths and the bus handshake state type.
 * assumes a 32-bit classic wishbone master and byte offsets in words of four.
 */

package pgh_gpio_pkg;

    // widths of the two ports
    localparam int PGH_PG_W = 5;
    localparam int PGH_PH_W = 8;

    // wishbone geometry
    localparam int PGH_ADR_W = 8;
    localparam int PGH_DAT_W = 32;
    localparam int PGH_SEL_W = 4;

    // register byte offsets
    localparam logic [7:0] PGH_OFS_PG_DIR = 8'h00;  // port_g_direction, write-only
    localparam logic [7:0] PGH_OFS_PG_OUT = 8'h04;  // port_g_output_latch
    localparam logic [7:0] PGH_OFS_PG_PIN = 8'h08;  // port_g_pin_state, read-only
    localparam logic [7:0] PGH_OFS_PH_DIR = 8'h0C;  // port_h_direction, write-only
    localparam logic [7:0] PGH_OFS_PH_OUT = 8'h10;  // port_h_output_latch
    localparam logic [7:0] PGH_OFS_PH_PIN = 8'h14;  // port_h_pin_state, read-only

    // reset values
    localparam logic [4:0] PGH_PG_RST = 5'h00;
    localparam logic [7:0] PGH_PH_RST = 8'h00;
    localparam logic [31:0] PGH_DAT_RST = 32'h0000_0000;

    // port g bits that vanish in the reduced variant
    localparam logic [4:0] PGH_PG_REDUCED_MASK = 5'h0C;

    // port g field positions
    localparam int PGH_PG_CS0 = 4;
    localparam int PGH_PG_RX = 3;
    localparam int PGH_PG_TX = 2;
    localparam int PGH_PG_CS3 = 1;
    localparam int PGH_PG_EXT_INTERRUPT_REQ_6 = 0;

    // chip select input indices
    localparam int PGH_CS0 = 0;
    localparam int PGH_CS1 = 1;
    localparam int PGH_CS2 = 2;
    localparam int PGH_CS3 = 3;

    // bus handshake states, gray along idle -> answer
    typedef enum logic [1:0] {
        PGH_BUS_IDLE = 2'b00,
        PGH_BUS_ACK = 2'b01
    } pgh_bus_state_t;

endpackage : pgh_gpio_pkg

// [hdl/pgh_gpio.sv]
/*
 * pgh_gpio: port g (5 bits, multiplexed) and port h (8 bits) i/o logic.
 * holds direction and output latches, synchronises pin levels, builds the
 * pin-state read path and the per-pin function selection, and answers a
 * classic wishbone slave with one wait state.
 * assumes the bus controller supplies active-low chip selects, the serial
 * bus unit supplies its transmit level and enable, and the pad ring resolves
 * each pin from the output and output-enable pairs.
 */
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module pgh_gpio
    import pgh_gpio_pkg::*;
#(
    // 1 selects the reduced variant without port g bits 3 and 2
    parameter logic P_REDUCED = 1'b0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [PGH_ADR_W-1:0] i_wb_adr,
    input wire logic [PGH_SEL_W-1:0] i_wb_sel,
    input wire logic [PGH_DAT_W-1:0] i_wb_dat,
    output logic [PGH_DAT_W-1:0] o_wb_dat,
    output logic o_wb_ack,
    // operating mode and neighbouring units
    input wire logic i_expanded_mode,
    input wire logic i_serial_bus_enable,
    input wire logic [3:0] i_chip_select_n,
    input wire logic i_serial_tx,
    // port g pins
    input wire logic [PGH_PG_W-1:0] i_pg_pin,
    output logic [PGH_PG_W-1:0] o_pg_pin_out,
    output logic [PGH_PG_W-1:0] o_pg_pin_oe,
    // port h pins
    input wire logic [PGH_PH_W-1:0] i_ph_pin,
    output logic [PGH_PH_W-1:0] o_ph_pin_out,
    output logic [PGH_PH_W-1:0] o_ph_pin_oe,
    // levels handed to the serial bus unit and interrupt controller
    output logic o_serial_rx,
    output logic o_ext_interrupt_req_6,
    output logic o_ext_interrupt_req_7
);

    // bits that exist in this variant
    localparam logic [4:0] PG_LIVE = P_REDUCED ? ~PGH_PG_REDUCED_MASK : 5'h1F;

    // bus handshake state
    pgh_bus_state_t bus_ff;
    pgh_bus_state_t nxt_bus;
    logic [PGH_DAT_W-1:0] rdat_ff;  // read data returned with ack
    logic [PGH_DAT_W-1:0] nxt_rdat;
    // the acknowledge has a flop of its own so the port carries no decode
    logic ack_ff;  // bus answer, high for one cycle
    logic nxt_ack;

    // software-visible storage
    logic [PGH_PG_W-1:0] pg_dir_ff;  // port_g_direction
    logic [PGH_PG_W-1:0] nxt_pg_dir;
    logic [PGH_PG_W-1:0] pg_out_ff;  // port_g_output_latch
    logic [PGH_PG_W-1:0] nxt_pg_out;
    logic [PGH_PH_W-1:0] ph_dir_ff;  // port_h_direction
    logic [PGH_PH_W-1:0] nxt_ph_dir;
    logic [PGH_PH_W-1:0] ph_out_ff;  // port_h_output_latch
    logic [PGH_PH_W-1:0] nxt_ph_out;

    // pin synchronisers: first stage feeds only the second
    // the pins come from outside the clock domain, hence two stages
    logic [PGH_PG_W-1:0] pg_meta_ff;
    logic [PGH_PG_W-1:0] pg_sync_ff;
    logic [PGH_PH_W-1:0] ph_meta_ff;
    logic [PGH_PH_W-1:0] ph_sync_ff;

    // registered pad drive
    logic [PGH_PG_W-1:0] pg_pad_out_ff;
    logic [PGH_PG_W-1:0] nxt_pg_pad_out;
    logic [PGH_PG_W-1:0] pg_pad_oe_ff;
    logic [PGH_PG_W-1:0] nxt_pg_pad_oe;
    logic [PGH_PH_W-1:0] ph_pad_out_ff;
    logic [PGH_PH_W-1:0] nxt_ph_pad_out;
    logic [PGH_PH_W-1:0] ph_pad_oe_ff;
    logic [PGH_PH_W-1:0] nxt_ph_pad_oe;

    // decoded request
    logic req;  // new request seen while idle
    logic wr_lane0;  // write reaching the low byte
    logic [PGH_PG_W-1:0] pg_state;  // port g pin-state view
    logic [PGH_PH_W-1:0] ph_state;  // port h pin-state view

    // request is taken only from idle so each cycle gets exactly one ack
    assign req = i_wb_cyc && i_wb_stb && (bus_ff == PGH_BUS_IDLE);
    // a write lands at the edge where the master samples ack; the master holds
    // address, data and select until then, so they are still valid here
    assign wr_lane0 = (bus_ff == PGH_BUS_ACK) && i_wb_cyc && i_wb_stb
        && i_wb_we && i_wb_sel[0];

    // pin-state views: latch for outputs, synchronised pin for inputs
    always_comb begin
        pg_state = (pg_dir_ff & pg_out_ff) | (~pg_dir_ff & pg_sync_ff);
        pg_state = pg_state & PG_LIVE;  // absent bits read as zero
        ph_state = (ph_dir_ff & ph_out_ff) | (~ph_dir_ff & ph_sync_ff);
    end

    // bus handshake: idle -> ack for one cycle -> idle
    // a master that keeps strobe up past ack is seen again only from idle
    always_comb begin
        nxt_bus = bus_ff;
        nxt_ack = 1'b0;  // ack stands for one cycle only
        case (bus_ff)
            PGH_BUS_IDLE: begin
                // answer the request one edge after it appears
                if (req) begin
                    nxt_bus = PGH_BUS_ACK;
                    nxt_ack = 1'b1;
                end
            end
            PGH_BUS_ACK: begin
                // ack drops in the cycle after it was given
                nxt_bus = PGH_BUS_IDLE;
            end
            default: begin
                nxt_bus = PGH_BUS_IDLE;
            end
        endcase
    end

    // read mux; unmapped offsets and write-only registers read as zero
    always_comb begin
        nxt_rdat = PGH_DAT_RST;
        if (req && !i_wb_we) begin
            case (i_wb_adr)
                PGH_OFS_PG_OUT: begin
                    // reserved bits 7..5 read as zero
                    nxt_rdat = {27'h000_0000, pg_out_ff};
                end
                PGH_OFS_PG_PIN: begin
                    nxt_rdat = {27'h000_0000, pg_state};
                end
                PGH_OFS_PH_OUT: begin
                    nxt_rdat = {24'h00_0000, ph_out_ff};
                end
                PGH_OFS_PH_PIN: begin
                    nxt_rdat = {24'h00_0000, ph_state};
                end
                PGH_OFS_PH_DIR: begin
                    // direction cannot be read back
                    nxt_rdat = PGH_DAT_RST;
                end
                default: begin
                    nxt_rdat = PGH_DAT_RST;
                end
            endcase
        end
    end

    // register writes, low byte lane only; upper lanes carry nothing here
    // and a write with the low lane disabled leaves every register alone
    always_comb begin
        nxt_pg_dir = pg_dir_ff;
        nxt_pg_out = pg_out_ff;
        nxt_ph_dir = ph_dir_ff;
        nxt_ph_out = ph_out_ff;
        if (wr_lane0) begin
            case (i_wb_adr)
                PGH_OFS_PG_DIR: begin
                    nxt_pg_dir = i_wb_dat[PGH_PG_W-1:0] & PG_LIVE;
                end
                PGH_OFS_PG_OUT: begin
                    // bits 7..5 dropped, absent bits held at zero
                    nxt_pg_out = i_wb_dat[PGH_PG_W-1:0] & PG_LIVE;
                end
                PGH_OFS_PH_DIR: begin
                    // whole byte replaced on every write
                    nxt_ph_dir = i_wb_dat[PGH_PH_W-1:0];
                end
                PGH_OFS_PH_OUT: begin
                    nxt_ph_out = i_wb_dat[PGH_PH_W-1:0];
                end
                default: begin
                    // pin-state registers and holes ignore writes
                    nxt_pg_dir = pg_dir_ff;
                end
            endcase
        end
    end

    // port g pin function selection
    always_comb begin
        nxt_pg_pad_out = pg_out_ff;
        nxt_pg_pad_oe = pg_dir_ff;
        // bit 4: chip select 0 in expanded mode, else gpio
        if (i_expanded_mode && pg_dir_ff[PGH_PG_CS0]) begin
            nxt_pg_pad_out[PGH_PG_CS0] = i_chip_select_n[PGH_CS0];
        end
        // bit 3: serial receive input overrides direction
        if (i_serial_bus_enable) begin
            nxt_pg_pad_oe[PGH_PG_RX] = 1'b0;
        end else if (i_expanded_mode && pg_dir_ff[PGH_PG_RX]) begin
            nxt_pg_pad_out[PGH_PG_RX] = i_chip_select_n[PGH_CS1];
        end
        // bit 2: serial transmit output overrides direction
        if (i_serial_bus_enable) begin
            nxt_pg_pad_oe[PGH_PG_TX] = 1'b1;
            nxt_pg_pad_out[PGH_PG_TX] = i_serial_tx;
        end else if (i_expanded_mode && pg_dir_ff[PGH_PG_TX]) begin
            nxt_pg_pad_out[PGH_PG_TX] = i_chip_select_n[PGH_CS2];
        end
        // bit 1: chip select 3 in expanded mode, else gpio
        if (i_expanded_mode && pg_dir_ff[PGH_PG_CS3]) begin
            nxt_pg_pad_out[PGH_PG_CS3] = i_chip_select_n[PGH_CS3];
        end
        // bit 0 stays a plain gpio in every mode
        // pins absent in the reduced variant are never driven
        nxt_pg_pad_out = nxt_pg_pad_out & PG_LIVE;
        nxt_pg_pad_oe = nxt_pg_pad_oe & PG_LIVE;
    end

    // port h pads: latch driven where direction is output
    always_comb begin
        nxt_ph_pad_out = ph_out_ff;
        nxt_ph_pad_oe = ph_dir_ff;
    end

    // bus state and read data
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            bus_ff <= PGH_BUS_IDLE;
            ack_ff <= 1'b0;
            rdat_ff <= PGH_DAT_RST;
        end else begin
            bus_ff <= nxt_bus;
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    // software-visible storage
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pg_dir_ff <= PGH_PG_RST;
            pg_out_ff <= PGH_PG_RST;
            ph_dir_ff <= PGH_PH_RST;
            ph_out_ff <= PGH_PH_RST;
        end else begin
            pg_dir_ff <= nxt_pg_dir;
            pg_out_ff <= nxt_pg_out;
            ph_dir_ff <= nxt_ph_dir;
            ph_out_ff <= nxt_ph_out;
        end
    end

    // two-stage pin synchronisers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pg_meta_ff <= PGH_PG_RST;
            pg_sync_ff <= PGH_PG_RST;
            ph_meta_ff <= PGH_PH_RST;
            ph_sync_ff <= PGH_PH_RST;
        end else begin
            pg_meta_ff <= i_pg_pin;
            pg_sync_ff <= pg_meta_ff;
            ph_meta_ff <= i_ph_pin;
            ph_sync_ff <= ph_meta_ff;
        end
    end

    // registered pad drive
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pg_pad_out_ff <= PGH_PG_RST;
            pg_pad_oe_ff <= PGH_PG_RST;
            ph_pad_out_ff <= PGH_PH_RST;
            ph_pad_oe_ff <= PGH_PH_RST;
        end else begin
            pg_pad_out_ff <= nxt_pg_pad_out;
            pg_pad_oe_ff <= nxt_pg_pad_oe;
            ph_pad_out_ff <= nxt_ph_pad_out;
            ph_pad_oe_ff <= nxt_ph_pad_oe;
        end
    end

    // outputs straight from flip-flops; the pad drive lags the latches by
    // one edge so a pin never glitches through the function multiplexer
    assign o_wb_ack = ack_ff;
    assign o_wb_dat = rdat_ff;
    assign o_pg_pin_out = pg_pad_out_ff;
    assign o_pg_pin_oe = pg_pad_oe_ff;
    assign o_ph_pin_out = ph_pad_out_ff;
    assign o_ph_pin_oe = ph_pad_oe_ff;
    // receive level follows pin 3; gated low-free, unit ignores it unless enabled
    assign o_serial_rx = pg_sync_ff[PGH_PG_RX];
    // interrupt pins feed their requests whatever the direction
    assign o_ext_interrupt_req_7 = pg_sync_ff[PGH_PG_CS3];
    assign o_ext_interrupt_req_6 = pg_sync_ff[PGH_PG_EXT_INTERRUPT_REQ_6];

endmodule : pgh_gpio

`default_nettype wire

// [testbench/pgh_gpio_asserts.sv]
/* pgh_gpio_asserts: port-level checks of the gpio block, bound to it.
   assumes a classic single-cycle master and a reset of several cycles. */
`timescale 1ns/1ps
`default_nettype none
module pgh_gpio_asserts
    import pgh_gpio_pkg::*;
#(
    parameter logic P_REDUCED = 1'b0
) (
    // clock, reset, bus
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [PGH_ADR_W-1:0] i_wb_adr,
    input wire logic [PGH_DAT_W-1:0] o_wb_dat,
    input wire logic o_wb_ack,
    // modes and pins
    input wire logic i_expanded_mode,
    input wire logic i_serial_bus_enable,
    input wire logic [3:0] i_chip_select_n,
    input wire logic i_serial_tx,
    input wire logic [PGH_PG_W-1:0] i_pg_pin,
    input wire logic [PGH_PG_W-1:0] o_pg_pin_out,
    input wire logic [PGH_PG_W-1:0] o_pg_pin_oe,
    input wire logic [PGH_PH_W-1:0] o_ph_pin_oe,
    input wire logic o_serial_rx,
    input wire logic o_ext_interrupt_req_6,
    input wire logic o_ext_interrupt_req_7
);
    // edges since reset, stops at three so history is clean
    logic [1:0] run_cnt_ff;
    logic [1:0] nxt_run_cnt;
    logic live;
    always_comb begin
        nxt_run_cnt = (run_cnt_ff == 2'h3) ? run_cnt_ff : run_cnt_ff + 2'h1;
        if (i_srst) begin
            nxt_run_cnt = 2'h0;
        end
    end
    always_ff @(posedge i_clk) begin
        run_cnt_ff <= nxt_run_cnt;
    end
    assign live = (run_cnt_ff == 2'h3);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    a_bus_answer: assert property (
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
        else $error("bus answer not a one-cycle pulse");
    a_g_reserved_zero: assert property (
        o_wb_ack && !i_wb_we && i_wb_adr < 8'h0c |-> o_wb_dat[31:5] == '0)
        else $error("port g read shows upper bits");
    a_ext_interrupt_req_6_sync: assert property (
        live |-> o_ext_interrupt_req_6 == $past(i_pg_pin[0], 2))
        else $error("request 6 not the synced pin");
    a_ext_interrupt_req_7_sync: assert property (
        live |-> o_ext_interrupt_req_7 == $past(i_pg_pin[1], 2))
        else $error("request 7 not the synced pin");
    a_rx_sync: assert property (
        live && !P_REDUCED |-> o_serial_rx == $past(i_pg_pin[3], 2))
        else $error("serial receive not the synced pin");
    a_serial_route: assert property (
        live && $past(i_serial_bus_enable) |-> !o_pg_pin_oe[3] &&
        (P_REDUCED || o_pg_pin_oe[2] && o_pg_pin_out[2] == $past(i_serial_tx)))
        else $error("serial pins wrongly routed");
    a_cs0_route: assert property (
        live && $past(i_expanded_mode) && o_pg_pin_oe[4]
        |-> o_pg_pin_out[4] == $past(i_chip_select_n[0]))
        else $error("chip select 0 not on its pin");
    // the write lands at the ack edge and the pad follows one edge later
    a_oe_after_write: assert property (
        live && $changed(o_ph_pin_oe) |-> $past(o_wb_ack, 2) && $past(i_wb_we, 2))
        else $error("port h enable moved without a write");
    // main scenarios reached
    c_write: cover property (i_wb_we && o_wb_ack);
    c_serial: cover property (live && i_serial_bus_enable && o_pg_pin_oe[2]);
    c_cs0: cover property (live && i_expanded_mode && o_pg_pin_oe[4]);
endmodule : pgh_gpio_asserts
bind pgh_gpio pgh_gpio_asserts #(.P_REDUCED(P_REDUCED)) i_pgh_gpio_asserts (.i_clk, .i_srst,
    .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack, .i_expanded_mode,
    .i_serial_bus_enable, .i_chip_select_n, .i_serial_tx, .i_pg_pin, .o_pg_pin_out,
    .o_pg_pin_oe, .o_ph_pin_oe, .o_serial_rx, .o_ext_interrupt_req_6, .o_ext_interrupt_req_7);
`default_nettype wire

// [testbench/pgh_pins_model.sv]
/* pgh_pins_model: the wires around the gpio pins.
   assumes outside sources change their level every iteration. */
`timescale 1ns/1ps
`default_nettype none
module pgh_pins_model
    import pgh_gpio_pkg::*;
(
    // drive from the block
    input wire logic [PGH_PG_W-1:0] i_g_out,
    input wire logic [PGH_PG_W-1:0] i_g_oe,
    input wire logic [PGH_PH_W-1:0] i_h_out,
    input wire logic [PGH_PH_W-1:0] i_h_oe,
    // levels of outside sources
    input wire logic [PGH_PG_W-1:0] i_g_ext,
    input wire logic [PGH_PH_W-1:0] i_h_ext,
    // resolved wire levels
    output logic [PGH_PG_W-1:0] o_g_pin,
    output logic [PGH_PH_W-1:0] o_h_pin
);
    // a driven wire follows the block, else the outside source
    assign o_g_pin = (i_g_oe & i_g_out) | (~i_g_oe & i_g_ext);
    assign o_h_pin = (i_h_oe & i_h_out) | (~i_h_oe & i_h_ext);
endmodule : pgh_pins_model
`default_nettype wire

// [testbench/tb.sv]
/* tb: self-checking bench of the port g / port h gpio block.
   assumes the block answers a bus request one cycle after taking it. */
`timescale 1ns/1ps
`default_nettype none
module tb
    import pgh_gpio_pkg::*;
;
    // stimulus
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic mode = 1'b0;
    logic sbe = 1'b0;
    logic tx = 1'b0;
    logic [3:0] cs_n = 4'hf;
    logic [4:0] ext_g = 5'h00;
    logic [7:0] ext_h = 8'h00;
    // design outputs and wires
    logic [31:0] rdat;
    logic ack, rx, ext_interrupt_req_6, ext_interrupt_req_7;
    logic [4:0] g_out, g_oe, g_pin;
    logic [7:0] h_out, h_oe, h_pin;
    // reduced variant outputs, wires and the read data it answered with
    logic [31:0] rdat_r, q_red;
    logic ext_interrupt_req_6_r, ext_interrupt_req_7_r;
    logic [4:0] g_out_r, g_oe_r, g_pin_r;
    // model state and counters
    int gd, gl, hd, hl, gp, hp, goe, gout, err_count, cmp_count;
    int seed = 32'hc90c_c9c6;
    logic [7:0] regs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h04};
    always #2.5 clk = ~clk;
    pgh_gpio #(.P_REDUCED(1'b0)) i_pgh_gpio (.i_clk(clk), .i_srst(srst), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_expanded_mode(mode), .i_serial_bus_enable(sbe),
        .i_chip_select_n(cs_n), .i_serial_tx(tx), .i_pg_pin(g_pin), .o_pg_pin_out(g_out),
        .o_pg_pin_oe(g_oe), .i_ph_pin(h_pin), .o_ph_pin_out(h_out), .o_ph_pin_oe(h_oe),
        .o_serial_rx(rx), .o_ext_interrupt_req_6(ext_interrupt_req_6), .o_ext_interrupt_req_7(ext_interrupt_req_7));
    pgh_pins_model i_pgh_pins_model (.i_g_out(g_out), .i_g_oe(g_oe), .i_h_out(h_out),
        .i_h_oe(h_oe), .i_g_ext(ext_g), .i_h_ext(ext_h), .o_g_pin(g_pin), .o_h_pin(h_pin));
    // reduced variant on the same bus and port h wires; its port g pins resolve here
    assign g_pin_r = (g_oe_r & g_out_r) | (~g_oe_r & ext_g);
    if (1'b1) begin : g_reduced
        pgh_gpio #(.P_REDUCED(1'b1)) i_pgh_gpio (.i_clk(clk), .i_srst(srst),
            .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
            .i_wb_dat(wdat), .o_wb_dat(rdat_r), .o_wb_ack(), .i_expanded_mode(mode),
            .i_serial_bus_enable(sbe), .i_chip_select_n(cs_n), .i_serial_tx(tx),
            .i_pg_pin(g_pin_r), .o_pg_pin_out(g_out_r), .o_pg_pin_oe(g_oe_r),
            .i_ph_pin(h_pin), .o_ph_pin_out(), .o_ph_pin_oe(), .o_serial_rx(),
            .o_ext_interrupt_req_6(ext_interrupt_req_6_r), .o_ext_interrupt_req_7(ext_interrupt_req_7_r));
    end
    // one compare, counted
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : chk
    // one classic cycle; waits for the answer, then idles a cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        // only the watchdog ends a wait that never sees ack
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        q_red = rdat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : bus
    // write; the model keeps only lane 0 of a mapped writable place
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        bus(1'b1, a, d, s, q);
        if (s[0]) begin
            case (a)
                PGH_OFS_PG_DIR: gd = d[4:0];
                PGH_OFS_PG_OUT: gl = d[4:0];
                PGH_OFS_PH_DIR: hd = d[7:0];
                PGH_OFS_PH_OUT: hl = d[7:0];
                default: ;
            endcase
        end
    endtask : wr
    // read and compare
    task automatic rd(input logic [7:0] a, input int e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, 4'hf, q);
        chk(q, e);
        chk(q_red, (a == PGH_OFS_PG_OUT || a == PGH_OFS_PG_PIN) ? e & 32'h13 : e);
    endtask : rd
    // pads, requests and every register except port_g_direction against the model
    task automatic check_all();
        goe = gd;
        gout = mode ? {cs_n[0], cs_n[1], cs_n[2], cs_n[3], gl[0]} : gl;
        if (sbe) begin
            goe = (gd & 5'h13) | 5'h04;
            gout = (gout & 5'h1b) | (tx << 2);
        end
        gp = (goe & gout) | (~goe & ext_g);
        hp = (hd & hl) | (~hd & ext_h);
        chk(g_oe, goe);
        chk(g_out & goe, gout & goe);
        chk({h_oe, h_out}, {hd[7:0], hl[7:0]});
        chk({rx, ext_interrupt_req_7, ext_interrupt_req_6}, {gp[3], gp[1], gp[0]});
        chk({g_oe_r, ext_interrupt_req_7_r, ext_interrupt_req_6_r}, {goe[4:0] & 5'h13, gp[1], gp[0]});
        chk(g_out_r & g_oe_r, gout & goe & 32'h13);
        rd(PGH_OFS_PG_OUT, gl);
        rd(PGH_OFS_PG_PIN, (gd & gl) | (~gd & gp));
        rd(PGH_OFS_PH_DIR, 0);
        rd(PGH_OFS_PH_OUT, hl);
        rd(PGH_OFS_PH_PIN, (hd & hl) | (~hd & hp));
        rd(8'h18, 0);
    endtask : check_all
    // counts, verdict, end of run
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    // random modes, levels and whole-byte writes, with one reset mid-run
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 60; i++) begin
            mode <= $random(seed);
            sbe <= $random(seed);
            tx <= $random(seed);
            cs_n <= $random(seed);
            ext_g <= $random(seed);
            ext_h <= $random(seed);
            if (i > 0) begin
                wr(regs[$unsigned($random(seed)) % 8], $random(seed), $random(seed));
            end
            if (i == 30) begin
                srst <= 1'b1;
                repeat (6) @(posedge clk);
                srst <= 1'b0;
                {gd, gl, hd, hl} = '0;
            end
            repeat (4) @(posedge clk);
            check_all();
        end
        test_done();
    end
    // cut a hang short
    initial begin
        #50000;
        err_count++;
        $display("wrong value at %0t: watchdog ran out", $time);
        test_done();
    end
endmodule : tb
`default_nettype wire
